// [src/gated_timer_pkg.sv]
package gated_timer_pkg;
    // bus and datapath widths
    localparam int ADDR_W    = 3;
    localparam int DATA_W    = 8;
    localparam int COUNT_W   = 16;
    localparam int PRESC_W   = 3;
    localparam int PSEL_W    = 2;
    localparam int GSRC_W    = 2;
    localparam int GATE_N    = 4;
    localparam int IRQ_W     = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_TIMER_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_GATE_CTRL  = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 3'h6;

    // timer_control_register fields
    localparam int CTRL_ON_BIT     = 0;
    localparam int CTRL_EXT_BIT    = 1;
    localparam int CTRL_BYPASS_BIT = 2;
    localparam int CTRL_PSEL_LSB   = 4;

    // gate_control_register fields
    localparam int GATE_SRC_LSB    = 0;
    localparam int GATE_VALUE_BIT  = 2;
    localparam int GATE_POL_BIT    = 6;
    localparam int GATE_EN_BIT     = 7;

    // interrupt status bits
    localparam int IRQ_OVF_BIT     = 0;
    localparam int IRQ_GATE_BIT    = 1;

    // reset values and limits
    localparam logic [DATA_W-1:0]  CTRL_RESET  = 8'h00;
    localparam logic [DATA_W-1:0]  GATE_RESET  = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;
    localparam logic [IRQ_W-1:0]   IRQ_RESET   = 2'h0;
    localparam logic [DATA_W-1:0]  DATA_ZERO   = 8'h00;
    localparam logic [DATA_W-1:0]  CTRL_MASK   = 8'h37;
    localparam logic [DATA_W-1:0]  GATE_MASK   = 8'hC3;
endpackage

// [src/prescale_divider.sv]
`timescale 1ns/1ps
// divides count ticks by 1, 2, 4 or 8
module prescale_divider
    import gated_timer_pkg::*;
(
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_reset_n,
    input  wire logic                                 i_tick,
    input  wire logic                                 i_clear,
    input  wire logic [gated_timer_pkg::PSEL_W-1:0]   i_select,
    output logic      [gated_timer_pkg::PRESC_W-1:0]  o_count,
    output logic                                      o_tick
);
    logic [PRESC_W-1:0] count;       // hidden prescale counter
    logic [PRESC_W-1:0] next_count;
    logic [PRESC_W-1:0] mask;        // ratio minus one
    logic               wrap;        // last tick of a division

    // mask is 0, 1, 3 or 7 for a ratio of 1, 2, 4 or 8
    always_comb begin
        mask       = PRESC_W'((4'h1 << i_select) - 4'h1);
        wrap       = i_tick && ((count & mask) == mask);
        next_count = count;
        if (i_clear) begin
            next_count = PRESC_RESET;
        end else if (wrap) begin
            next_count = PRESC_RESET;
        end else if (i_tick) begin
            next_count = count + 3'h1;
        end
    end

    // register the counter only
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= PRESC_RESET;
        end else begin
            count <= next_count;
        end
    end

    // a clear in the same cycle still lets the tick through
    assign o_tick  = wrap;
    assign o_count = count;
endmodule

// [src/gated_count_timer.sv]
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - prescaler divides count clock by 1/2/4/8
// - prescaler hidden, cleared by count byte write
// - bypass bit skips external clock synchroniser
// - async external mode counts and wakes in sleep
// - mode switch may drop or add one increment
// - count byte reads always return valid value
// - gate enable bit and polarity bit gate counting
// - gated mode counts on count clock rising edge
// - without gate, count every count clock tick
// - polarity picks active gate level for counting
// - gate input chosen from several sources
module gated_count_timer
    import gated_timer_pkg::*;
(
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_reset_n,
    input  wire logic [gated_timer_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [gated_timer_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                                 i_wr,
    input  wire logic                                 i_rd,
    input  wire logic                                 i_ext_clk,
    input  wire logic [gated_timer_pkg::GATE_N-1:0]   i_gate_input,
    input  wire logic                                 i_sleep,
    output logic      [gated_timer_pkg::DATA_W-1:0]   o_rdata,
    output logic                                      o_irq,
    output logic                                      o_wake
);
    // software-visible state
    logic [DATA_W-1:0]  ctrl;           // timer_control_register
    logic [DATA_W-1:0]  gate_ctrl;      // gate_control_register
    logic [COUNT_W-1:0] count;          // count_high_byte:count_low_byte
    logic [IRQ_W-1:0]   status;         // sticky events
    logic [IRQ_W-1:0]   irq_enable;     // interrupt enables
    logic [DATA_W-1:0]  next_ctrl;
    logic [DATA_W-1:0]  next_gate_ctrl;
    logic [COUNT_W-1:0] next_count;
    logic [IRQ_W-1:0]   next_status;
    logic [IRQ_W-1:0]   next_irq_enable;
    logic [DATA_W-1:0]  next_rdata;
    logic               next_irq;
    logic               next_wake;

    // count clock path state
    logic               ext_s1;         // synchroniser stage one
    logic               ext_s2;         // synchroniser stage two
    logic               ext_prev;       // previous selected level
    logic               gate_prev;      // previous gate activity
    logic               ext_src;        // selected external level
    logic               raw_tick;       // count clock rising edge
    logic               count_tick;     // tick allowed by gate etc
    logic               presc_tick;     // tick after the prescaler
    logic [PRESC_W-1:0] presc_count;    // watched by checks only
    logic               gate_level;     // selected gate source
    logic               gate_active;    // gate level after polarity
    logic               run_in_sleep;   // mode that survives sleep
    logic               count_write;    // write to either byte
    logic               wr_low;
    logic               wr_high;
    logic [IRQ_W-1:0]   events;

    // decoded control fields
    logic               timer_on;
    logic               ext_select;
    logic               sync_bypass;
    logic [PSEL_W-1:0]  prescale_select;
    logic [GSRC_W-1:0]  gate_select;
    logic               gate_enable_bit;
    logic               gate_polarity_bit;

    assign timer_on          = ctrl[CTRL_ON_BIT];
    assign ext_select        = ctrl[CTRL_EXT_BIT];
    assign sync_bypass       = ctrl[CTRL_BYPASS_BIT];
    assign prescale_select   = ctrl[CTRL_PSEL_LSB +: PSEL_W];
    assign gate_select       = gate_ctrl[GATE_SRC_LSB +: GSRC_W];
    assign gate_enable_bit   = gate_ctrl[GATE_EN_BIT];
    assign gate_polarity_bit = gate_ctrl[GATE_POL_BIT];

    // external clock synchroniser and previous-level flops; stage one feeds stage two only
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ext_s1    <= 1'b0;
            ext_s2    <= 1'b0;
            ext_prev  <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            ext_s1    <= i_ext_clk;
            ext_s2    <= ext_s1;
            ext_prev  <= ext_src;
            gate_prev <= gate_active;
        end
    end

    // count clock and gate qualification
    always_comb begin
        // bypass takes the pin straight, two cycles less latency;
        // the pin must then be clean to this clock
        ext_src = sync_bypass ? i_ext_clk : ext_s2;
        // toggling the bypass shifts latency by two cycles, so the
        // edge detector may miss or repeat one edge
        raw_tick = ext_select ? (ext_src && !ext_prev)
                              : 1'b1;  // internal: every mclk
        gate_level  = i_gate_input[gate_select];
        gate_active = gate_polarity_bit ? gate_level
                                        : !gate_level;
        // only the async external mode has a clock in sleep
        run_in_sleep = ext_select && sync_bypass;
        count_tick = timer_on && raw_tick
                  && (!gate_enable_bit || gate_active)
                  && (!i_sleep || run_in_sleep);
    end

    prescale_divider u_prescale (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_tick    (count_tick),
        .i_clear   (count_write),
        .i_select  (prescale_select),
        .o_count   (presc_count),
        .o_tick    (presc_tick)
    );

    // register file and counter next values
    always_comb begin
        wr_low          = i_wr && (i_addr == ADDR_COUNT_LOW);
        wr_high         = i_wr && (i_addr == ADDR_COUNT_HIGH);
        count_write     = wr_low || wr_high;
        next_ctrl       = ctrl;
        next_gate_ctrl  = gate_ctrl;
        next_irq_enable = irq_enable;
        next_count      = count;
        events          = IRQ_RESET;
        if (i_wr && i_addr == ADDR_TIMER_CTRL) begin
            next_ctrl = i_wdata & CTRL_MASK;
        end
        if (i_wr && i_addr == ADDR_GATE_CTRL) begin
            next_gate_ctrl = i_wdata & GATE_MASK;
        end
        if (i_wr && i_addr == ADDR_IRQ_ENABLE) begin
            next_irq_enable = i_wdata[IRQ_W-1:0];
        end
        // a write wins over a coinciding increment; software
        // should stop the timer first
        if (count_write) begin
            if (wr_low) begin
                next_count[7:0] = i_wdata;
            end
            if (wr_high) begin
                next_count[15:8] = i_wdata;
            end
        end else if (presc_tick) begin
            next_count = count + 16'h0001;
            if (count == COUNT_MAX) begin
                events[IRQ_OVF_BIT] = 1'b1;
            end
        end
        // gate closing while gated marks end of a measurement
        if (gate_enable_bit && timer_on && gate_prev && !gate_active) begin
            events[IRQ_GATE_BIT] = 1'b1;
        end
        // sticky flags; a new event beats a same-cycle clear
        next_status = status;
        if (i_wr && i_addr == ADDR_IRQ_CLEAR) begin
            next_status = status & ~i_wdata[IRQ_W-1:0];
        end
        next_status = next_status | events;
        next_irq    = |(next_status & next_irq_enable);
        // overflow in sleep wakes the core when the overflow interrupt is enabled
        next_wake   = events[IRQ_OVF_BIT] && i_sleep
                   && next_irq_enable[IRQ_OVF_BIT];
    end

    // read mux; count is one clock domain so bytes are never torn
    always_comb begin
        next_rdata = DATA_ZERO;
        if (i_rd) begin
            case (i_addr)
                ADDR_TIMER_CTRL: next_rdata = ctrl;
                ADDR_GATE_CTRL: begin
                    next_rdata = gate_ctrl;
                    next_rdata[GATE_VALUE_BIT] = gate_active;
                end
                ADDR_COUNT_LOW:  next_rdata = count[7:0];
                ADDR_COUNT_HIGH: next_rdata = count[15:8];
                ADDR_IRQ_STATUS: next_rdata = {6'h00, status};
                ADDR_IRQ_ENABLE: next_rdata = {6'h00, irq_enable};
                default:         next_rdata = DATA_ZERO;
            endcase
        end
    end

    // register the software-visible state and outputs
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl       <= CTRL_RESET;
            gate_ctrl  <= GATE_RESET;
            count      <= COUNT_RESET;
            status     <= IRQ_RESET;
            irq_enable <= IRQ_RESET;
            o_rdata    <= DATA_ZERO;
            o_irq      <= 1'b0;
            o_wake     <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            gate_ctrl  <= next_gate_ctrl;
            count      <= next_count;
            status     <= next_status;
            irq_enable <= next_irq_enable;
            o_rdata    <= next_rdata;
            o_irq      <= next_irq;
            o_wake     <= next_wake;
        end
    end

    // checks
    wrap_to_zero_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        presc_tick && !count_write && count == COUNT_MAX
        |=> count == COUNT_RESET && status[IRQ_OVF_BIT])
        else $error("count did not wrap with overflow flag");

    prescale_clear_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        count_write |=> presc_count == PRESC_RESET)
        else $error("prescaler not cleared by count write");

    divide_one_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        prescale_select == 2'h0 && count_tick |-> presc_tick)
        else $error("divide by one dropped a tick");

    divide_eight_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        presc_tick && prescale_select == 2'h3 |-> presc_count == 3'h7)
        else $error("divide by eight ticked early");

    gate_hold_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        gate_enable_bit && gate_level != gate_polarity_bit
        |-> !count_tick ##1 count == $past(count) || $past(count_write))
        else $error("counter moved while gate inactive");

    ungated_run_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        !gate_enable_bit && timer_on && raw_tick && !i_sleep
        |-> count_tick)
        else $error("ungated timer missed a tick");

    sleep_stop_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        i_sleep && !(ext_select && sync_bypass) |-> !count_tick)
        else $error("synchronous mode counted in sleep");

    irq_level_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        ##1 o_irq == |($past(next_status) & $past(next_irq_enable))
        && (o_irq || !(|(status & irq_enable))))
        else $error("interrupt level disagrees with flags");

    count_read_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        i_rd && i_addr == ADDR_COUNT_HIGH
        |=> o_rdata == $past(count[15:8]))
        else $error("high count byte read wrong");

    // synchronised path: a tick needs the pin high two cycles back
    sync_delay_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        ext_select && !sync_bypass && raw_tick
        |-> $past(i_ext_clk, 2))
        else $error("synchronised tick without earlier pin edge");

    // bypassed path: the raw pin edge is the tick, no delay
    bypass_direct_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        ext_select && sync_bypass && $past(sync_bypass)
        |-> raw_tick == (i_ext_clk && !$past(i_ext_clk)))
        else $error("bypassed pin edge not seen at once");

    // byte writes land even over a coinciding increment
    low_write_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        wr_low |=> count[7:0] == $past(i_wdata))
        else $error("low count byte write lost");

    high_write_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        wr_high |=> count[15:8] == $past(i_wdata))
        else $error("high count byte write lost");

    // count only moves on a prescaled tick or a write
    count_hold_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        !presc_tick && !count_write |=> $stable(count))
        else $error("count moved without a tick or write");

    // overflow flag stays until software clears it
    status_sticky_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        status[IRQ_OVF_BIT]
        && !(i_wr && i_addr == ADDR_IRQ_CLEAR && i_wdata[IRQ_OVF_BIT])
        |=> status[IRQ_OVF_BIT])
        else $error("overflow flag dropped without a clear");

    // a wake pulse only follows an overflow taken in sleep
    wake_cause_a: assert property (
        @(posedge i_mclk) disable iff (!i_reset_n)
        o_wake |-> $past(i_sleep) && $past(presc_tick)
                && $past(count) == COUNT_MAX)
        else $error("wake pulse without overflow in sleep");
endmodule

// [testbench/gated_count_timer_test.sv]
`timescale 1ns/1ps
module gated_count_timer_test import gated_timer_pkg::*;;
    logic                i_mclk;          // system clock, 25 ns
    logic                i_reset_n;       // async reset, active low
    logic [ADDR_W-1:0]   i_addr;          // register address
    logic [DATA_W-1:0]   i_wdata;         // write data
    logic                i_wr;            // write strobe
    logic                i_rd;            // read strobe
    logic                i_ext_clk;       // external count clock
    logic [GATE_N-1:0]   i_gate_input;    // gate sources
    logic                i_sleep;         // core asleep
    logic [DATA_W-1:0]   o_rdata;         // read data, one cycle late
    logic                o_irq;           // level interrupt
    logic                o_wake;          // wake pulse
    int                  bad_count;       // mismatches seen
    int                  samples_checked; // comparisons made
    int                  wake_n;          // wake pulses counted

    gated_count_timer dut (
        .i_mclk       (i_mclk),
        .i_reset_n    (i_reset_n),
        .i_addr       (i_addr),
        .i_wdata      (i_wdata),
        .i_wr         (i_wr),
        .i_rd         (i_rd),
        .i_ext_clk    (i_ext_clk),
        .i_gate_input (i_gate_input),
        .i_sleep      (i_sleep),
        .o_rdata      (o_rdata),
        .o_irq        (o_irq),
        .o_wake       (o_wake)
    );

    // free-running system clock
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    // wake is one cycle wide, so count every cycle it is seen high
    // sampled at the falling edge, where the pulse has settled
    always @(negedge i_mclk) begin
        if (o_wake === 1'b1) begin
            wake_n++;
        end
    end

    // one comparison, reported at once on mismatch
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    // one-cycle read strobe; data stands only in the following cycle
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
                       input logic [7:0] mask = 8'hFF);
        logic [7:0] got;
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1 got = o_rdata;
        chk(got & mask, exp);
    endtask

    // count bytes are written low then high, timer stopped by caller except in the prescale clear test
    task automatic setcnt(input logic [15:0] v);
        wr(ADDR_COUNT_LOW, v[7:0]);
        wr(ADDR_COUNT_HIGH, v[15:8]);
    endtask

    // byte-wise read is safe here because the count clock is idle
    task automatic cnt(input logic [15:0] exp);
        rdc(ADDR_COUNT_LOW, exp[7:0]);
        rdc(ADDR_COUNT_HIGH, exp[15:8]);
    endtask

    // slow external edges: 2 cycles high, 3 low, then let sync settle
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            i_ext_clk <= 1'b1;
            repeat (2) @(posedge i_mclk);
            i_ext_clk <= 1'b0;
            repeat (2) @(posedge i_mclk);
        end
        repeat (6) @(posedge i_mclk);
    endtask

    // registered irq level, give it two cycles
    task automatic irqchk(input logic exp);
        repeat (2) @(posedge i_mclk);
        #1 chk({7'h00, o_irq}, {7'h00, exp});
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog well beyond the thousand or so cycles the tests need
    initial begin
        #(25 * 20000);
        bad_count++;
        $display("FAIL at %0t: watchdog expired", $time);
        finish_test();
    end

    // main sequence
    initial begin
        bad_count = 0;
        samples_checked = 0;
        wake_n = 0;
        i_reset_n = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_ext_clk = 1'b0;
        i_gate_input = 4'h0;
        i_sleep = 1'b0;
        repeat (5) @(posedge i_mclk);
        i_reset_n <= 1'b1;

        // reset values, masks, unmapped and write-only places
        rdc(ADDR_TIMER_CTRL, 8'h00);
        rdc(ADDR_GATE_CTRL, 8'h00, 8'hC3);
        cnt(16'h0000);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        rdc(ADDR_IRQ_ENABLE, 8'h00);
        wr(ADDR_TIMER_CTRL, 8'hFF);
        rdc(ADDR_TIMER_CTRL, 8'h37);
        wr(3'h7, 8'hFF);
        rdc(3'h7, 8'h00);
        rdc(ADDR_IRQ_CLEAR, 8'h00);
        wr(ADDR_TIMER_CTRL, 8'h00);
        $display("test registers done");

        // internal clock: one increment per system clock while on
        setcnt(16'h0000);
        wr(ADDR_TIMER_CTRL, 8'h01);
        repeat (10) @(posedge i_mclk);
        wr(ADDR_TIMER_CTRL, 8'h00);
        cnt(16'h000C);
        $display("test internal clock done");

        // every prescale setting, gate disabled, active gate level
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_TIMER_CTRL, 8'h00);
            setcnt(16'h0000);
            wr(ADDR_TIMER_CTRL, 8'(p << 4) | 8'h03);
            pulse(8);
            cnt(16'(8 >> p));
        end
        $display("test prescaler done");

        // prescale counter cleared by a count write in mid-division
        wr(ADDR_TIMER_CTRL, 8'h00);
        setcnt(16'h0000);
        wr(ADDR_TIMER_CTRL, 8'h23);
        pulse(3);
        setcnt(16'h0010);
        pulse(3);
        cnt(16'h0010);
        pulse(1);
        cnt(16'h0011);
        $display("test prescale clear done");

        // gate polarity against gate level, all four combinations
        for (int pol = 0; pol < 2; pol++) begin
            for (int lvl = 0; lvl < 2; lvl++) begin
                wr(ADDR_TIMER_CTRL, 8'h00);
                i_gate_input <= {GATE_N{lvl[0]}};
                wr(ADDR_GATE_CTRL, 8'h80 | 8'(pol << 6));
                setcnt(16'h0000);
                wr(ADDR_TIMER_CTRL, 8'h03);
                pulse(4);
                cnt((pol == lvl) ? 16'h0004 : 16'h0000);
            end
        end
        $display("test gate polarity done");

        // each gate source alone, then every source but the chosen one
        for (int s = 0; s < GATE_N; s++) begin
            for (int inv = 0; inv < 2; inv++) begin
                wr(ADDR_TIMER_CTRL, 8'h00);
                i_gate_input <= inv ? ~(4'h1 << s) : (4'h1 << s);
                wr(ADDR_GATE_CTRL, 8'hC0 | 8'(s));
                setcnt(16'h0000);
                wr(ADDR_TIMER_CTRL, 8'h03);
                pulse(2);
                cnt(inv ? 16'h0000 : 16'h0002);
            end
        end
        // gate closing while counting raises the gate event flag
        rdc(ADDR_IRQ_STATUS, 8'h00, 8'h02);
        @(posedge i_mclk);
        i_gate_input <= 4'hF;
        repeat (2) @(posedge i_mclk);
        i_gate_input <= 4'h0;
        repeat (2) @(posedge i_mclk);
        rdc(ADDR_IRQ_STATUS, 8'h02, 8'h02);
        wr(ADDR_IRQ_CLEAR, 8'h02);
        rdc(ADDR_IRQ_STATUS, 8'h00, 8'h02);
        wr(ADDR_GATE_CTRL, 8'h00);
        $display("test gate source done");

        // overflow in bypass mode, then mask, unmask and clear
        wr(ADDR_TIMER_CTRL, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        setcnt(16'hFFFF);
        wr(ADDR_TIMER_CTRL, 8'h07);
        pulse(1);
        cnt(16'h0000);
        rdc(ADDR_IRQ_STATUS, 8'h01, 8'h01);
        irqchk(1'b1);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        irqchk(1'b0);
        rdc(ADDR_IRQ_ENABLE, 8'h00);
        rdc(ADDR_IRQ_STATUS, 8'h01, 8'h01);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        irqchk(1'b1);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        irqchk(1'b0);
        rdc(ADDR_IRQ_STATUS, 8'h00, 8'h01);
        $display("test overflow irq done");

        // bypass shows a pin edge one cycle on, the synchroniser later
        for (int b = 0; b < 2; b++) begin
            wr(ADDR_TIMER_CTRL, 8'h00);
            setcnt(16'h0000);
            wr(ADDR_TIMER_CTRL, b ? 8'h07 : 8'h03);
            @(posedge i_mclk);
            i_ext_clk <= 1'b1;
            rdc(ADDR_COUNT_LOW, b ? 8'h01 : 8'h00);
            @(posedge i_mclk);
            i_ext_clk <= 1'b0;
            repeat (6) @(posedge i_mclk);
            cnt(16'h0001);
        end
        $display("test sync bypass done");

        // overflow while asleep in async external mode wakes the core
        wr(ADDR_TIMER_CTRL, 8'h00);
        setcnt(16'hFFFF);
        i_sleep <= 1'b1;
        wr(ADDR_TIMER_CTRL, 8'h07);
        wake_n = 0;
        pulse(2);
        i_sleep <= 1'b0;
        chk(8'(wake_n), 8'h01);
        cnt(16'h0001);

        // synchronised counting stops while the core sleeps
        wr(ADDR_TIMER_CTRL, 8'h03);
        i_sleep <= 1'b1;
        pulse(2);
        i_sleep <= 1'b0;
        cnt(16'h0001);
        $display("test sleep wake done");

        finish_test();
    end
endmodule
